// *** inc/board_id_consts.svh ***
// named offsets, fields, reset values and timing for the board id bank
`ifndef BOARD_ID_CONSTS_SVH
`define BOARD_ID_CONSTS_SVH

// ----------------------------------------------------------------
// host i/o offsets
// ----------------------------------------------------------------
`define IO_ADDR_W 16
`define OFS_REVISION_TYPE 16'h01d1
`define OFS_JUMPER_INPUTS 16'h01d2
`define OFS_WD_ACTION_STATUS 16'h01d3

// ----------------------------------------------------------------
// board identity straps (revision value is arbitrary)
// ----------------------------------------------------------------
`define LOGIC_REVISION_CODE 5'h03
`define TEMP_GRADE_IND 1'h0
`define BUILD_CLASS_CUSTOM 1'h0
`define MATURITY_BETA 1'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define REV_CODE_HI 7
`define REV_CODE_LO 3
`define REV_TEMP_BIT 2
`define REV_CLASS_BIT 1
`define REV_BETA_BIT 0
`define JMP_ONE_BIT 1
`define JMP_TWO_BIT 0
`define WD_PIN_BIT 7
`define WD_SEL_HI 5
`define WD_SEL_LO 4
`define WD_MON_ST_BIT 3
`define WD_ROUTE_HI 1
`define WD_ROUTE_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WD_SEL_RESET 2'h0
`define WD_ROUTE_RESET 2'h0
`define RDATA_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define COLD_OFF_SEC 4
`define COLD_OFF_CYCLES (`COLD_OFF_SEC * `CLK_HZ)
`define COLD_CNT_W 28

`endif

// *** inc/board_id_pkg.sv ***
// types shared by the board id bank and its watchdog action controller
package board_id_pkg;

   typedef enum logic [1:0] {
      WD_ACT_NONE = 2'h0,
      WD_ACT_WARM = 2'h1,
      WD_ACT_COLD = 2'h2,
      WD_ACT_UNDEF = 2'h3
   } wd_action_e;

   typedef enum logic [1:0] {
      WD_IDLE,
      WD_WARM,
      WD_COLD
   } wd_state_e;

endpackage

// *** inc/wd_action_if.sv ***
// signals between the register bank and the watchdog action controller
interface wd_action_if;
   import board_id_pkg::*;
   wd_action_e action_sel;
   logic timeout;
   logic warm_reset;
   logic power_off;
   logic busy;

   modport regs (output action_sel, output timeout,
      input warm_reset, input power_off, input busy);
   modport ctrl (input action_sel, input timeout,
      output warm_reset, output power_off, output busy);
endinterface

// *** core/wd_action_ctrl.sv ***
// reacts to a watchdog timeout with warm reset or timed power removal
`include "board_id_consts.svh"

module wd_action_ctrl
   import board_id_pkg::*;
#(
   parameter logic [`COLD_CNT_W-1:0] COLD_OFF_CYCLES =
      `COLD_CNT_W'(`COLD_OFF_CYCLES)
) (
   input wire logic clk,
   input wire logic rst_n,
   wd_action_if.ctrl wd
);

   wd_state_e state_r;
   logic [`COLD_CNT_W-1:0] cnt_r;

   // ----------------------------------------------------------------
   // action sequencer
   // ----------------------------------------------------------------
   // timeouts during an action are dropped; the board is resetting anyway
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= WD_IDLE;
      end else begin
         case (state_r)
            WD_IDLE: begin
               if (wd.timeout) begin
                  case (wd.action_sel)
                     WD_ACT_WARM: state_r <= WD_WARM;
                     WD_ACT_COLD: state_r <= WD_COLD;
                     default: state_r <= WD_IDLE;
                  endcase
               end
            end
            WD_WARM: state_r <= WD_IDLE;
            WD_COLD: begin
               if (cnt_r == COLD_OFF_CYCLES - 1'b1) begin
                  state_r <= WD_IDLE;
               end
            end
            default: state_r <= WD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // power-off timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || state_r != WD_COLD) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign wd.warm_reset = (state_r == WD_WARM);
   assign wd.power_off = (state_r == WD_COLD);
   assign wd.busy = (state_r != WD_IDLE);

endmodule

// *** core/board_id_jumper_watchdog_regs.sv ***
// byte-wide board id, jumper and watchdog registers on the host i/o path
`include "board_id_consts.svh"

// How it works
// - revision register top five bits hold a fixed logic revision code.
// - revision bit 2 reports temperature grade, 1 means industrial, read-only.
// - revision bit 1 reports build class, 1 means customized, read-only.
// - jumper register bits 7 to 2 carry nothing.
// - jumper bit 1 reads 1 while the first jumper is fitted.
// - jumper bit 0 reads 1 while the second jumper is fitted.
// - watchdog register chooses the reaction to the watchdog pin asserting.
// - watchdog register layout: status 7, select 5:4, monitor 3, route 1:0.
// - select 00 nothing, 01 warm reset, 10 power off about four seconds.
// - watchdog status bit reads the inverse of the watchdog pin.
module board_id_jumper_watchdog_regs
   import board_id_pkg::*;
#(
   parameter logic [`COLD_CNT_W-1:0] COLD_OFF_CYCLES =
      `COLD_CNT_W'(`COLD_OFF_CYCLES)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`IO_ADDR_W-1:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_hit,
   input wire logic jumper_input_one,
   input wire logic jumper_input_two,
   input wire logic watchdog_pin,
   input wire logic monitor_irq_state,
   output logic [1:0] monitor_irq_route,
   output logic warm_reset_req,
   output logic power_off_req
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic [2:0] decode(input logic [`IO_ADDR_W-1:0] a);
      decode = {a == `OFS_WD_ACTION_STATUS, a == `OFS_JUMPER_INPUTS,
         a == `OFS_REVISION_TYPE};
   endfunction

   logic [2:0] sel;
   wd_action_e action_sel_r;
   logic [1:0] route_r;
   logic wd_pin_prev_r;
   logic [7:0] rdata_r;
   logic [7:0] rev_byte;
   logic [7:0] jmp_byte;
   logic [7:0] wd_byte;
   logic [7:0] rdata_nxt;

   wd_action_if wd();

   assign sel = decode(io_addr);
   // unclaimed addresses belong to other devices on the shared i/o path
   assign io_hit = (io_rd || io_wr) && (sel != 3'h0);

   // ----------------------------------------------------------------
   // writable watchdog fields
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         action_sel_r <= wd_action_e'(`WD_SEL_RESET);
         route_r <= `WD_ROUTE_RESET;
      end else if (io_wr && sel[2]) begin
         // status bits and reserved bits of this byte are not stored
         action_sel_r <= wd_action_e'(io_wdata[`WD_SEL_HI:`WD_SEL_LO]);
         route_r <= io_wdata[`WD_ROUTE_HI:`WD_ROUTE_LO];
      end
   end

   // ----------------------------------------------------------------
   // timeout detect: pin going low flags the timeout
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wd_pin_prev_r <= 1'b1;
      end else begin
         wd_pin_prev_r <= watchdog_pin;
      end
   end

   assign wd.timeout = wd_pin_prev_r && !watchdog_pin;
   assign wd.action_sel = action_sel_r;

   wd_action_ctrl #(
      .COLD_OFF_CYCLES(COLD_OFF_CYCLES)
   ) u_wd_action (
      .clk(clk),
      .rst_n(rst_n),
      .wd(wd.ctrl)
   );

   assign warm_reset_req = wd.warm_reset;
   assign power_off_req = wd.power_off;
   assign monitor_irq_route = route_r;

   // ----------------------------------------------------------------
   // read bytes
   // ----------------------------------------------------------------
   always_comb begin
      rev_byte = 8'h00;
      rev_byte[`REV_CODE_HI:`REV_CODE_LO] = `LOGIC_REVISION_CODE;
      rev_byte[`REV_TEMP_BIT] = `TEMP_GRADE_IND;
      rev_byte[`REV_CLASS_BIT] = `BUILD_CLASS_CUSTOM;
      rev_byte[`REV_BETA_BIT] = `MATURITY_BETA;
   end

   always_comb begin
      jmp_byte = 8'h00;
      jmp_byte[`JMP_ONE_BIT] = jumper_input_one;
      jmp_byte[`JMP_TWO_BIT] = jumper_input_two;
   end

   always_comb begin
      wd_byte = 8'h00;
      wd_byte[`WD_PIN_BIT] = !watchdog_pin;
      wd_byte[`WD_SEL_HI:`WD_SEL_LO] = action_sel_r;
      wd_byte[`WD_MON_ST_BIT] = monitor_irq_state;
      wd_byte[`WD_ROUTE_HI:`WD_ROUTE_LO] = route_r;
   end

   always_comb begin
      case (sel)
         3'h1: rdata_nxt = rev_byte;
         3'h2: rdata_nxt = jmp_byte;
         3'h4: rdata_nxt = wd_byte;
         default: rdata_nxt = `RDATA_RESET;
      endcase
   end

   // ----------------------------------------------------------------
   // read data register
   // ----------------------------------------------------------------
   // one-cycle latency keeps the data output off combinational paths
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= `RDATA_RESET;
      end else if (io_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign io_rdata = rdata_r;

endmodule

// *** dv/board_id_regs_chk_sva.sv ***
// port checks for the board id, jumper and watchdog bank
`include "board_id_consts.svh"
module board_id_regs_chk
   import board_id_pkg::*;
#(
   parameter logic [`COLD_CNT_W-1:0] COLD_OFF_CYCLES =
      `COLD_CNT_W'(`COLD_OFF_CYCLES)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`IO_ADDR_W-1:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   input wire logic jumper_input_one,
   input wire logic jumper_input_two,
   input wire logic watchdog_pin,
   input wire logic monitor_irq_state,
   input wire logic [1:0] monitor_irq_route,
   input wire logic warm_reset_req,
   input wire logic power_off_req
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [`COLD_CNT_W-1:0] high_cnt_r;
   logic [1:0] wr_route;
   assign wr_route = io_wdata[1:0];
   // counts power-off length; too long for a repetition
   always_ff @(posedge clk) begin
      if (!rst_n || !power_off_req) begin
         high_cnt_r <= '0;
      end else begin
         high_cnt_r <= high_cnt_r + 1'b1;
      end
   end
   a_rev_fixed: assert property (
      io_rd && io_addr == `OFS_REVISION_TYPE |=> io_rdata == {
      `LOGIC_REVISION_CODE, `TEMP_GRADE_IND, `BUILD_CLASS_CUSTOM,
      `MATURITY_BETA}) else $error("revision byte wrong");
   a_jmp_bits: assert property (
      io_rd && io_addr == `OFS_JUMPER_INPUTS |=> io_rdata ==
      {6'h00, $past(jumper_input_one), $past(jumper_input_two)})
      else $error("jumper byte wrong");
   a_wd_byte: assert property (
      io_rd && io_addr == `OFS_WD_ACTION_STATUS |=>
      io_rdata[7] == !$past(watchdog_pin) && io_rdata[6] == 1'b0 &&
      io_rdata[3] == $past(monitor_irq_state) && io_rdata[2] == 1'b0 &&
      io_rdata[1:0] == $past(monitor_irq_route))
      else $error("watchdog byte wrong");
   a_unmapped_zero: assert property (
      io_rd && !io_hit |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_hit_decode: assert property (
      io_hit == ((io_rd || io_wr) && io_addr >= `OFS_REVISION_TYPE &&
      io_addr <= `OFS_WD_ACTION_STATUS)) else $error("decode wrong");
   a_rdata_hold: assert property (
      !io_rd |=> $stable(io_rdata)) else $error("read data moved");
   a_route_write: assert property (
      io_wr && io_addr == `OFS_WD_ACTION_STATUS |=>
      monitor_irq_route == $past(wr_route)) else $error("route lost");
   a_warm_pulse: assert property (
      warm_reset_req |-> $past(watchdog_pin, 2) && !$past(watchdog_pin)
      ##1 !warm_reset_req) else $error("warm pulse wrong");
   a_cold_start: assert property (
      $rose(power_off_req) |-> $past(watchdog_pin, 2) &&
      !$past(watchdog_pin)) else $error("power off without timeout");
   a_cold_len: assert property (
      $fell(power_off_req) && $past(rst_n) |->
      high_cnt_r == COLD_OFF_CYCLES) else $error("power off too short");
   a_cold_cap: assert property (
      power_off_req |-> high_cnt_r < COLD_OFF_CYCLES)
      else $error("power off too long");
endmodule
bind board_id_jumper_watchdog_regs board_id_regs_chk
   #(.COLD_OFF_CYCLES(COLD_OFF_CYCLES)) chk_u (.*);

// *** dv/host_io_model.sv ***
// host side issuing single-byte i/o reads and writes
`include "board_id_consts.svh"
module host_io_model (
   input wire logic clk,
   input wire logic [7:0] io_rdata,
   output logic [`IO_ADDR_W-1:0] io_addr,
   output logic io_rd,
   output logic io_wr,
   output logic [7:0] io_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      io_addr = '0;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      d = io_rdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
endmodule

// *** dv/board_id_jumper_watchdog_regs_tb_top.sv ***
// self-checking bench for the board id, jumper and watchdog bank
`include "board_id_consts.svh"
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module board_id_jumper_watchdog_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // short power-off so the run stays brief
   localparam logic [`COLD_CNT_W-1:0] COLD = 28'h14;
   localparam logic [7:0] REV_EXP = {`LOGIC_REVISION_CODE,
      `TEMP_GRADE_IND, `BUILD_CLASS_CUSTOM, `MATURITY_BETA};
   logic clk = 0, rst_n = 0, jumper_input_one = 0, jumper_input_two = 0;
   logic watchdog_pin = 1, monitor_irq_state = 0, io_rd, io_wr, io_hit;
   logic warm_reset_req, power_off_req;
   logic [`IO_ADDR_W-1:0] io_addr;
   logic [7:0] io_wdata, io_rdata, rd_byte;
   logic [1:0] monitor_irq_route;
   int n_mismatch = 0, cmp_count = 0, warm_n = 0, off_n = 0;
   host_io_model host_u (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));
   board_id_jumper_watchdog_regs #(.COLD_OFF_CYCLES(COLD)) dut_u (
      .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_hit(io_hit), .jumper_input_one(jumper_input_one),
      .jumper_input_two(jumper_input_two), .watchdog_pin(watchdog_pin),
      .monitor_irq_state(monitor_irq_state),
      .monitor_irq_route(monitor_irq_route),
      .warm_reset_req(warm_reset_req), .power_off_req(power_off_req));
   initial forever #12.5 clk = ~clk;
   always @(negedge clk) begin
      // an unknown request counts as a pulse so it cannot slip through
      warm_n += int'(warm_reset_req !== 1'b0);
      off_n += int'(power_off_req !== 1'b0);
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_ident();
      host_u.rd(`OFS_WD_ACTION_STATUS, rd_byte);
      `CMP(rd_byte, 8'h00)
      host_u.wr(`OFS_REVISION_TYPE, 8'hff);
      host_u.wr(`OFS_JUMPER_INPUTS, 8'hff);
      host_u.rd(`OFS_REVISION_TYPE, rd_byte);
      `CMP(rd_byte, REV_EXP)
      host_u.rd(16'h01d0, rd_byte);
      `CMP(rd_byte, 8'h00)
      host_u.rd(16'h01d4, rd_byte);
      `CMP(rd_byte, 8'h00)
   endtask
   task automatic t_jumpers();
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         {jumper_input_one, jumper_input_two} = 2'(i);
         host_u.rd(`OFS_JUMPER_INPUTS, rd_byte);
         `CMP(rd_byte, {6'h00, 2'(i)})
      end
   endtask
   // reserved and status bits written as ones must not stick
   task automatic t_watchdog(input logic [1:0] sel);
      host_u.wr(`OFS_WD_ACTION_STATUS, {2'h3, sel, 2'h3, ~sel});
      `CMP(monitor_irq_route, ~sel)
      warm_n = 0;
      off_n = 0;
      watchdog_pin = 1'b0;
      monitor_irq_state = sel[0];
      host_u.rd(`OFS_WD_ACTION_STATUS, rd_byte);
      `CMP(rd_byte, {2'h2, sel, sel[0], 1'b0, ~sel})
      repeat (int'(COLD) + 8) @(negedge clk);
      `CMP(warm_n, int'(sel == 2'h1))
      `CMP(off_n, (sel == 2'h2) ? int'(COLD) : 0)
      watchdog_pin = 1'b1;
      host_u.rd(`OFS_WD_ACTION_STATUS, rd_byte);
      `CMP(rd_byte[7], 1'b0)
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_ident();
      t_jumpers();
      for (int s = 0; s < 4; s++) t_watchdog(2'(s));
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
